// ### core/lapdtx_map.svh
// register map, field positions, frame constants and timing for the lapd transmitter
// assumes an 8-bit register port and a 10 MHz framer transmit clock
`ifndef LAPDTX_MAP_SVH
`define LAPDTX_MAP_SVH

`define LAPDTX_CFG_ADDR 8'h33
`define LAPDTX_STAT_ADDR 8'h34

`define LAPDTX_CFG_ENABLE 0
`define LAPDTX_CFG_SIZE 1
`define LAPDTX_CFG_REPEAT 3
`define LAPDTX_ST_IRQ_FLAG 0
`define LAPDTX_ST_IRQ_EN 1
`define LAPDTX_ST_BUSY 2
`define LAPDTX_ST_START 3

`define LAPDTX_CFG_RESET 3'h0
`define LAPDTX_STAT_RESET 8'h00

`define LAPDTX_FLAG 8'h7e
`define LAPDTX_SAPI_CR 8'h3c
`define LAPDTX_TEI 8'h01
`define LAPDTX_CTRL 8'h03
`define LAPDTX_HDR_BYTES 7'h03
`define LAPDTX_LEN_SHORT 7'h4c
`define LAPDTX_LEN_LONG 7'h52
`define LAPDTX_STUFF_RUN 3'h5

`define LAPDTX_CRC_INIT 16'hffff
`define LAPDTX_CRC_POLY 16'h8408

`define LAPDTX_CLK_HZ 10000000
`define LAPDTX_REPEAT_S 1
`define LAPDTX_REPEAT_CYCLES (`LAPDTX_CLK_HZ * `LAPDTX_REPEAT_S)

`endif

// ### core/lapdtx_pkg.sv
// types shared by the lapd transmitter files
// assumes lapdtx_map.svh carries all numeric constants
package lapdtx_pkg;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_FILL = 3'h1,
    ST_OPEN = 3'h2,
    ST_BODY = 3'h3,
    ST_FCS = 3'h4,
    ST_CLOSE = 3'h5
  } lapdtx_state_type;

  typedef struct packed {
    logic auto_repeat;
    logic size_sel;
    logic enable;
  } lapdtx_cfg_type;

endpackage

// ### core/lapdtx_crc_step.sv
// one serial step of the frame check, reflected x^16+x^12+x^5+1
// assumes data bits enter least significant bit first
`timescale 1ns/1ps
`include "lapdtx_map.svh"

module lapdtx_crc_step import lapdtx_pkg::*; #(
  parameter int WIDTH = 16
) (
  // state in and out
  input wire logic [WIDTH-1:0] crc_in,
  input wire logic din,
  output logic [WIDTH-1:0] crc_out
);

  generate
    if (WIDTH != 16) begin : g_bad_width
      $error("lapdtx_crc_step only serves a 16-bit check");
    end
  endgenerate

  always_comb begin
    crc_out = crc_in >> 1;
    if (crc_in[0] ^ din) begin
      crc_out = crc_out ^ `LAPDTX_CRC_POLY;
    end
  end

endmodule

// ### core/lapdtx_top.sv
// lapd message transmitter: frames a buffered message into the e3 n overhead bit
// assumes one n-slot strobe per outbound e3 frame, strobes at least two clocks apart,
// and a message buffer read port whose data is valid one clock after the index
`timescale 1ns/1ps
`include "lapdtx_map.svh"

module lapdtx_top import lapdtx_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `LAPDTX_REPEAT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  // message buffer read port
  output logic [6:0] msg_rd_index,
  input wire logic [7:0] msg_rd_data,
  // framer n overhead bit
  input wire logic n_slot_strobe,
  output logic n_bit_out
);

  generate
    if (SEC_CYCLES < 2 || SEC_CYCLES > 32'h7fffffff) begin : g_bad_sec
      $error("SEC_CYCLES out of range");
    end
  endgenerate

  lapdtx_cfg_type cfg_r;
  logic irq_en_r;
  logic irq_flag_r;
  logic start_r;
  logic busy_r;
  logic sent_once_r;
  logic [31:0] sec_cnt_r;
  logic sec_tick_r;
  lapdtx_state_type state_r;
  logic [15:0] shreg_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] byte_idx_r;
  logic [2:0] ones_r;
  logic stuff_r;
  logic [15:0] crc_r;
  logic [15:0] crc_step;
  logic [15:0] crc_nxt;
  logic [7:0] rdata_r;
  logic irq_r;
  logic [6:0] rd_index_r;
  logic n_bit_r;

  logic wr_cfg;
  logic wr_stat;
  logic rd_stat;
  logic start_rise;
  logic launch_ok;
  logic start_accept;
  logic repeat_accept;
  logic advance;
  logic byte_end;
  logic done;
  logic stuffing_zone;
  logic [3:0] last_bit;
  logic [6:0] frame_last;
  logic [7:0] next_byte;

  assign wr_cfg = reg_wr && (reg_addr == `LAPDTX_CFG_ADDR);
  assign wr_stat = reg_wr && (reg_addr == `LAPDTX_STAT_ADDR);
  assign rd_stat = reg_rd && (reg_addr == `LAPDTX_STAT_ADDR);
  assign start_rise = wr_stat && reg_wdata[`LAPDTX_ST_START] && !start_r;
  assign launch_ok = cfg_r.enable && !busy_r;
  assign start_accept = start_rise && launch_ok;
  assign repeat_accept = sec_tick_r && cfg_r.auto_repeat && sent_once_r && launch_ok;

  assign stuffing_zone = (state_r == ST_BODY) || (state_r == ST_FCS);
  // one bit per strobe; a pending stuffed zero holds the shifter
  assign advance = n_slot_strobe && (state_r != ST_OFF) && !stuff_r;
  assign last_bit = (state_r == ST_FCS) ? 4'hf : 4'h7;
  assign byte_end = advance && (bit_cnt_r == last_bit);
  assign done = byte_end && (state_r == ST_CLOSE);
  // information field length from the size bit
  assign frame_last = `LAPDTX_HDR_BYTES +
                      (cfg_r.size_sel ? `LAPDTX_LEN_LONG : `LAPDTX_LEN_SHORT);

  // endpoint and control octets; payload from buffer
  always_comb begin
    case (byte_idx_r)
      7'h01: next_byte = `LAPDTX_TEI;
      7'h02: next_byte = `LAPDTX_CTRL;
      default: next_byte = msg_rd_data;
    endcase
  end

  lapdtx_crc_step #(.WIDTH(16)) u_crc (
    .crc_in(crc_r),
    .din(shreg_r[0]),
    .crc_out(crc_step)
  );
  assign crc_nxt = (advance && state_r == ST_BODY) ? crc_step : crc_r;

  // configuration register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_r <= `LAPDTX_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r.auto_repeat <= reg_wdata[`LAPDTX_CFG_REPEAT];
      cfg_r.size_sel <= reg_wdata[`LAPDTX_CFG_SIZE];
      cfg_r.enable <= reg_wdata[`LAPDTX_CFG_ENABLE];
    end
  end

  // status register writable bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_en_r <= 1'b0;
      start_r <= 1'b0;
    end else if (wr_stat) begin
      irq_en_r <= reg_wdata[`LAPDTX_ST_IRQ_EN];
      start_r <= reg_wdata[`LAPDTX_ST_START];
    end
  end

  // completion flag; a completion in the reading cycle survives the read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_flag_r <= 1'b0;
    end else if (done && irq_en_r) begin
      irq_flag_r <= 1'b1;
    end else if (rd_stat) begin
      irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_flag_r && irq_en_r;
    end
  end

  // busy from launch until the closing flag is out
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (!cfg_r.enable || done) begin
      busy_r <= 1'b0;
    end else if (start_accept || repeat_accept) begin
      busy_r <= 1'b1;
    end
  end

  // repeats only follow a real start and stop on disable
  always_ff @(posedge clock) begin
    if (!rst_n || !cfg_r.enable) begin
      sent_once_r <= 1'b0;
    end else if (start_accept) begin
      sent_once_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sec_cnt_r <= 32'h0;
      sec_tick_r <= 1'b0;
    end else if (sec_cnt_r == SEC_CYCLES - 1) begin
      sec_cnt_r <= 32'h0;
      sec_tick_r <= 1'b1;
    end else begin
      sec_cnt_r <= sec_cnt_r + 32'h1;
      sec_tick_r <= 1'b0;
    end
  end

  // count ones in header, payload and check; flags are never stuffed
  always_ff @(posedge clock) begin
    if (!rst_n || state_r == ST_OFF) begin
      ones_r <= 3'h0;
      stuff_r <= 1'b0;
    end else if (n_slot_strobe && stuff_r) begin
      ones_r <= 3'h0;
      stuff_r <= 1'b0;
    end else if (advance && stuffing_zone) begin
      if (!shreg_r[0]) begin
        ones_r <= 3'h0;
      end else if (ones_r == `LAPDTX_STUFF_RUN - 3'h1) begin
        ones_r <= 3'h0;
        stuff_r <= 1'b1;
      end else begin
        ones_r <= ones_r + 3'h1;
      end
    end
  end

  // check accumulates data bits only, never stuffed zeros
  always_ff @(posedge clock) begin
    if (!rst_n || state_r == ST_OPEN) begin
      crc_r <= `LAPDTX_CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  // frame sequencer; disable drops any frame in flight at once
  always_ff @(posedge clock) begin
    if (!rst_n || !cfg_r.enable) begin
      state_r <= ST_OFF;
      shreg_r <= 16'h0;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 7'h0;
      rd_index_r <= 7'h0;
    end else if (state_r == ST_OFF) begin
      state_r <= ST_FILL;
      shreg_r <= {8'h00, `LAPDTX_FLAG};
      bit_cnt_r <= 4'h0;
    end else if (byte_end) begin
      bit_cnt_r <= 4'h0;
      case (state_r)
        ST_FILL: begin
          // launches wait for a flag boundary so no flag is cut short
          state_r <= busy_r ? ST_OPEN : ST_FILL;
          shreg_r <= {8'h00, `LAPDTX_FLAG};
        end
        ST_OPEN: begin
          // header generated after the opening flag
          state_r <= ST_BODY;
          shreg_r <= {8'h00, `LAPDTX_SAPI_CR};
          byte_idx_r <= 7'h1;
          rd_index_r <= 7'h0;
        end
        ST_BODY: begin
          if (byte_idx_r == frame_last) begin
            // check sent complemented, low bit first
            state_r <= ST_FCS;
            shreg_r <= ~crc_nxt;
          end else begin
            shreg_r <= {8'h00, next_byte};
            byte_idx_r <= byte_idx_r + 7'h1;
            if (byte_idx_r >= `LAPDTX_HDR_BYTES) begin
              rd_index_r <= byte_idx_r - `LAPDTX_HDR_BYTES + 7'h1;
            end
          end
        end
        ST_FCS: begin
          state_r <= ST_CLOSE;
          shreg_r <= {8'h00, `LAPDTX_FLAG};
        end
        ST_CLOSE: begin
          state_r <= ST_FILL;
          shreg_r <= {8'h00, `LAPDTX_FLAG};
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end else if (advance) begin
      shreg_r <= shreg_r >> 1;
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // disabled line carries ones; one bit per strobe otherwise
  always_ff @(posedge clock) begin
    if (!rst_n || !cfg_r.enable || state_r == ST_OFF) begin
      n_bit_r <= 1'b1;
    end else if (n_slot_strobe) begin
      n_bit_r <= stuff_r ? 1'b0 : shreg_r[0];
    end
  end

  // register read port; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_r <= `LAPDTX_STAT_RESET;
    end else if (reg_rd) begin
      if (reg_addr == `LAPDTX_CFG_ADDR) begin
        rdata_r <= {4'h0, cfg_r.auto_repeat, 1'b0, cfg_r.size_sel, cfg_r.enable};
      end else if (reg_addr == `LAPDTX_STAT_ADDR) begin
        rdata_r <= {4'h0, start_r, busy_r, irq_en_r, irq_flag_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign msg_rd_index = rd_index_r;
  assign n_bit_out = n_bit_r;

  // the forced one lands the edge after enable is seen low, so look a cycle later
  a_off_line_ones: assert property (@(posedge clock) disable iff (!rst_n)
    !cfg_r.enable ##1 !cfg_r.enable |-> n_bit_out)
    else $error("n bit not held at one while disabled");

  a_fill_flag_bits: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r.enable && state_r == ST_FILL && n_slot_strobe && !stuff_r
    |=> n_bit_out == $past(shreg_r[0]))
    else $error("idle flag bit not emitted");

  a_stuff_zero_out: assert property (@(posedge clock) disable iff (!rst_n)
    advance && stuffing_zone && shreg_r[0] && ones_r == 3'h4 && cfg_r.enable
    |=> stuff_r ##0 (!n_slot_strobe [*1] or (n_slot_strobe ##1 !n_bit_out)))
    else $error("no zero after five ones");

  a_start_busy: assert property (@(posedge clock) disable iff (!rst_n)
    start_accept |=> busy_r && sent_once_r)
    else $error("start did not raise busy");

  a_busy_holds: assert property (@(posedge clock) disable iff (!rst_n)
    busy_r && cfg_r.enable && !done |=> busy_r)
    else $error("busy dropped early");

  a_done_idle: assert property (@(posedge clock) disable iff (!rst_n)
    done && cfg_r.enable |=> !busy_r && state_r == ST_FILL)
    else $error("busy or state wrong after frame");

  a_repeat_tick: assert property (@(posedge clock) disable iff (!rst_n)
    sec_tick_r && cfg_r.auto_repeat && sent_once_r && cfg_r.enable && !busy_r |=> busy_r)
    else $error("repeat not launched on tick");

  a_once_no_repeat: assert property (@(posedge clock) disable iff (!rst_n)
    sec_tick_r && !cfg_r.auto_repeat && !busy_r && !start_rise |=> !busy_r)
    else $error("single-shot frame repeated");

  a_len_to_fcs: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r.enable && state_r == ST_BODY && byte_end
    && byte_idx_r == (cfg_r.size_sel ? 7'h55 : 7'h4f)
    |=> state_r == ST_FCS && bit_cnt_r == 4'h0)
    else $error("payload length wrong");

  a_hdr_first: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r.enable && state_r == ST_OPEN && byte_end
    |=> state_r == ST_BODY && shreg_r[7:0] == 8'h3c)
    else $error("header octet not generated");

  a_irq_set: assert property (@(posedge clock) disable iff (!rst_n)
    done && irq_en_r |=> irq_flag_r ##1 (irq || !irq_en_r))
    else $error("completion interrupt missing");

  a_irq_read_clr: assert property (@(posedge clock) disable iff (!rst_n)
    rd_stat && !(done && irq_en_r) |=> !irq_flag_r)
    else $error("flag not cleared by read");

endmodule

// ### test/lapdtx_framer_model.sv
// n overhead bit consumer: paces slot strobes and unpacks hdlc frames
// assumes n_bit_out answers one clock after each strobe
`timescale 1ns/1ps
module lapdtx_framer_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // strobe spacing in clocks, at least 2
  input wire logic [7:0] gap,
  // n bit link
  output logic n_slot_strobe,
  input wire logic n_bit_out,
  // unpacked frames
  output logic [7:0] frm [0:95],
  output logic [7:0] frm_len,
  output logic [15:0] frm_cnt,
  output logic [15:0] flag_cnt
);
  logic [7:0] cnt_r;
  logic take_r;
  logic [3:0] ones;
  logic bits [$];
  int n;

  initial begin
    n_slot_strobe = 1'b0;
    take_r = 1'b0;
  end

  always @(posedge clock) begin
    take_r <= n_slot_strobe;
    if (!rst_n) begin
      cnt_r <= 8'h00;
      n_slot_strobe <= 1'b0;
      frm_cnt <= 16'h0000;
      flag_cnt <= 16'h0000;
      frm_len <= 8'h00;
      ones = 4'h0;
      bits.delete();
    end else begin
      // one strobe per gap, so strobes never come closer than two clocks
      n_slot_strobe <= (cnt_r >= gap - 8'h01);
      cnt_r <= (cnt_r >= gap - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      if (take_r && n_bit_out) begin
        bits.push_back(1'b1);
        ones = (ones == 4'hf) ? ones : ones + 4'h1;
      end else if (take_r) begin
        if (ones == 4'h6) begin
          flag_cnt <= flag_cnt + 16'h0001;
          n = bits.size() - 7;
          if (n >= 8) begin
            frm_len <= (n % 8 == 0) ? 8'(n / 8) : 8'hff;
            for (int i = 0; i < n && i < 768; i++) frm[i / 8][i % 8] <= bits[i];
            frm_cnt <= frm_cnt + 16'h0001;
          end
          bits.delete();
        end else if (ones > 4'h6) bits.delete();
        else if (ones != 4'h5) bits.push_back(1'b0);
        ones = 4'h0;
      end
    end
  end
endmodule

// ### test/lapdtx_top_tb.sv
// self-checking bench for the lapd message transmitter
// assumes the framer model beside it and a shortened repeat second
`timescale 1ns/1ps
module lapdtx_top_tb import lapdtx_pkg::*;;
  localparam int SEC = 6000;
  logic clock, rst_n, reg_wr, reg_rd, irq, n_slot_strobe, n_bit_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, msg_rd_data, gap, frm_len, rv;
  logic [6:0] msg_rd_index;
  logic [7:0] frm [0:95];
  logic [7:0] mem [0:127];
  logic [15:0] frm_cnt, flag_cnt, lfsr, f0;
  int bad_count, n_checks, t0, t1, cyc, k;

  lapdtx_top #(.SEC_CYCLES(SEC)) dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .msg_rd_index(msg_rd_index), .msg_rd_data(msg_rd_data), .n_slot_strobe(n_slot_strobe),
    .n_bit_out(n_bit_out));
  lapdtx_framer_model far_end (.clock(clock), .rst_n(rst_n), .gap(gap),
    .n_slot_strobe(n_slot_strobe), .n_bit_out(n_bit_out), .frm(frm), .frm_len(frm_len),
    .frm_cnt(frm_cnt), .flag_cnt(flag_cnt));

  always #50 clock = ~clock;
  // message buffer answers one clock after the index
  always @(posedge clock) begin
    cyc <= cyc + 1;
    msg_rd_data <= mem[msg_rd_index];
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test done: %s", s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    check({8'h00, reg_rdata}, {8'h00, want}, "register read");
  endtask

  // start bit written low then high, with the irq enable given
  task automatic start(input logic [7:0] ien);
    wr(8'h34, ien);
    wr(8'h34, ien | 8'h08);
  endtask

  task automatic fill(input logic sz, input logic corner);
    mem[0] = sz ? 8'h3f : 8'h38;
    for (int i = 1; i < 82; i++) begin
      lfsr = lfsr_next(lfsr);
      mem[i] = (corner && (i < 16 || i > 70)) ? ((i % 3 == 0) ? 8'h7e : 8'hff) : lfsr[7:0];
    end
    lfsr = lfsr_next(lfsr);
    gap <= 8'h02 + {6'h00, lfsr[1:0]};
  endtask

  task automatic wait_frame(input int limit);
    f0 = frm_cnt;
    k = 0;
    while (frm_cnt === f0 && k < limit) begin
      @(posedge clock);
      k++;
    end
    check(frm_cnt, f0 + 16'h0001, "frame count");
    t0 = t1;
    t1 = cyc;
  endtask

  task automatic hold_one(input int span);
    k = 0;
    repeat (span) begin
      @(posedge clock);
      if (n_bit_out !== 1'b1) k++;
    end
    check(k[15:0], 16'h0000, "n bit not held high");
  endtask

  task automatic check_frame(input logic sz);
    logic [7:0] e [0:89];
    logic [15:0] crc;
    int n;
    n = sz ? 82 : 76;
    e[0] = 8'h3c;
    e[1] = 8'h01;
    e[2] = 8'h03;
    for (int i = 0; i < n; i++) e[3 + i] = mem[i];
    crc = 16'hffff;
    for (int i = 0; i < n + 3; i++)
      for (int b = 0; b < 8; b++)
        crc = (crc[0] ^ e[i][b]) ? ((crc >> 1) ^ 16'h8408) : (crc >> 1);
    e[n + 3] = ~crc[7:0];
    e[n + 4] = ~crc[15:8];
    check({8'h00, frm_len}, 16'(n + 5), "frame length");
    for (int i = 0; i < n + 5; i++) check({8'h00, frm[i]}, {8'h00, e[i]}, "frame byte");
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    msg_rd_data = 8'h00;
    gap = 8'h03;
    lfsr = 16'hca5e;
    cyc = 0;
    bad_count = 0;
    n_checks = 0;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(8'h33, 8'h00);
    rdc(8'h34, 8'h00);
    rdc(8'h5a, 8'h00);
    wr(8'h33, 8'hff);
    rdc(8'h33, 8'h0b);
    wr(8'h33, 8'h00);
    start(8'h00);
    rdc(8'h34, 8'h08);
    hold_one(60);
    done("registers and disabled line");
    wr(8'h34, 8'h00);
    wr(8'h33, 8'h01);
    f0 = flag_cnt;
    repeat (576) @(posedge clock);
    check({15'h0000, (flag_cnt - f0 >= 16'h0016) && (flag_cnt - f0 <= 16'h0018)}, 16'h0001, "flags");
    done("idle flags");
    fill(1'b0, 1'b1);
    start(8'h02);
    repeat (100) @(posedge clock);
    rdc(8'h34, 8'h0e);
    start(8'h02);
    wait_frame(2 * SEC);
    check_frame(1'b0);
    repeat (3) @(posedge clock);
    check({15'h0000, irq}, 16'h0001, "irq after frame");
    rdc(8'h34, 8'h0b);
    rdc(8'h34, 8'h0a);
    check({15'h0000, irq}, 16'h0000, "irq after read");
    f0 = frm_cnt;
    repeat (SEC + 600) @(posedge clock);
    check(frm_cnt, f0, "resent without repeat");
    done("single frame with interrupt");
    wr(8'h33, 8'h03);
    fill(1'b1, 1'b0);
    start(8'h00);
    wait_frame(2 * SEC);
    check_frame(1'b1);
    repeat (3) @(posedge clock);
    check({15'h0000, irq}, 16'h0000, "irq while masked");
    rdc(8'h34, 8'h08);
    done("long frame masked");
    wr(8'h33, 8'h09);
    fill(1'b0, 1'b0);
    start(8'h00);
    repeat (3) wait_frame(2 * SEC);
    check_frame(1'b0);
    check({15'h0000, (t1 - t0 >= SEC - 64) && (t1 - t0 <= SEC + 64)}, 16'h0001, "interval");
    wr(8'h33, 8'h08);
    f0 = frm_cnt;
    hold_one(SEC + 600);
    check(frm_cnt, f0, "frame after disable");
    done("repeat each second");
    complete_run;
  end

  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run;
  end
endmodule
